// File: bench/bssq_scale_model.sv
// Scale front end model: weight rises while the block feeds
`timescale 1ns/1ps
module bssq_scale_model (
  input  wire logic        clk,        // System clock
  input  wire logic        load,       // Force a new weight
  input  wire logic [15:0] load_val,   // Weight to force
  input  wire logic        feed,       // Feed output of the block
  output logic             standstill, // Scale settled
  output logic             gross_zero, // Gross at zero
  output logic             in_range,   // Within capacity
  output logic [15:0]      weight      // Current weight
);
  logic [2:0] calm;                    // Quiet cycles since feed
  // Weight climbs one count per cycle of feed; settles four cycles later
  always_ff @(posedge clk)
  begin
    if (load)
      weight <= load_val;
    else if (feed)
      weight <= weight + 16'h0001;
    calm       <= feed ? 3'h0 : {calm[1:0], 1'b1};
    standstill <= !feed && calm[2];
  end
  assign gross_zero = (weight == 16'h0000);
  assign in_range   = (weight < 16'h9000);
endmodule

// File: bench/bssq_top_test.sv
// Self-checking bench for the batch setpoint sequencer
`timescale 1ns/1ps
module bssq_top_test;
  logic clk = 0, rstn = 0, we = 0, ld = 1, bsr = 0, arm = 1, stp = 0;
  logic [2:0] adr = 3'h0, cs, ws = 3'h1, we2 = 3'h2, cst = 3'h1, ce = 3'h2;
  logic [20:0] wd = 21'h000000;
  logic [1:0] mode = 2'h0;
  logic [15:0] ldv = 16'h0008, w, wdv = 16'h0001, ccv = 16'h0000;
  logic [15:0] dv = 16'h0004, ov = 16'h0064, uv = 16'h0032;
  logic [16:0] tnow = 17'h00000, tset = 17'h00005;
  logic ss, gz, ir, act, fo, zc, mm, rm, wdo, cco, tm, dm, co, cu, ca, jo;
  logic [2:0] p;
  logic [15:0] tw [4] = '{16'h0078, 16'h001e, 16'h0046, 16'h9000};
  logic [3:0] te [4] = '{4'h9, 4'h5, 4'h3, 4'h8};
  int error_cnt = 0, samples_checked = 0, n, k, j;
  always #2.5 clk = ~clk;
  bssq_scale_model bssq_scale_model_inst (.clk(clk), .load(ld),
    .load_val(ldv), .feed(fo), .standstill(ss), .gross_zero(gz),
    .in_range(ir), .weight(w));
  bssq_top #(.TICK_CYCLES(10)) bssq_top_inst (.clk(clk), .rstn(rstn),
    .cfg_we(we), .cfg_addr(adr), .cfg_wdata(wd), .batching_mode(mode),
    .batch_start_request(bsr), .batch_stop(stp), .standstill(ss),
    .gross_zero(gz), .in_range(ir), .weight(w), .wd_start_step(ws),
    .wd_end_step(we2), .wd_value(wdv), .cc_start_step(cst),
    .cc_end_step(ce), .cc_value(ccv), .tod_now(tnow), .tod_set(tset),
    .delta_arm(arm), .delta_value(dv), .chk_over(ov), .chk_under(uv),
    .current_step(cs), .batch_active_monitor(act), .feed_out(fo),
    .jog_out(jo), .zero_centre_monitor(zc), .motion_monitor(mm),
    .range_monitor(rm), .watchdog_out(wdo), .concur_out(cco),
    .clock_match_setpoint(tm), .delta_met(dm), .chk_over_out(co),
    .chk_under_out(cu), .chk_accept_out(ca));
  // Compare one value, count it, report a mismatch
  task automatic chk(input string nm, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Step table write and forced scale weight
  task automatic wr(input logic [2:0] a, input logic [20:0] d);
    we = 1; adr = a; wd = d; cyc(1); we = 0; cyc(1);
  endtask
  task automatic setw(input logic [15:0] v);
    ld = 1; ldv = v; cyc(1); ld = 0; cyc(2);
  endtask
  task automatic wait_step(input logic [2:0] s);
    for (n = 0; cs !== s && n < 500; n++) cyc(1);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    cyc(12); rstn = 1; setw(16'h0000);
    chk("mon", 16'h0005, {13'h0, zc, mm, rm});
    for (int i = 0; i < 4; i++)
    begin
      setw(tw[i]);
      chk("chkw", {12'h0, te[i]}, {12'h0, co, cu, ca, rm});
    end
    setw(16'h0046); arm = 0; setw(16'h0049);
    chk("delta lo", 16'h0000, {15'h0, dm});
    setw(16'h004a);
    chk("delta hi", 16'h0001, {15'h0, dm});
    tnow = 17'h00005; n = 0;
    repeat (6) begin cyc(1); n += tm; end
    chk("tod", 16'h0001, n[15:0]);
    $display("monitor tests done");
    wr(3'h0, {1'b1, 4'h1, 16'h0010}); wr(3'h1, {1'b0, 4'h2, 16'h0003});
    wr(3'h2, {1'b0, 4'h6, 16'h0000});
    for (int i = 3; i < 8; i++) wr(i[2:0], {1'b0, 4'h7, 16'h0000});
    setw(16'h0008); mode = bssq_pkg::MODE_MANUAL; cyc(20);
    chk("idle", 16'h0000, {15'h0, act});
    bsr = 1; cyc(3); bsr = 0; cyc(6);
    chk("run", 16'h0003, {14'h0, act, fo});
    chk("motion", 16'h0001, {15'h0, mm});
    wait_step(3'h1); cyc(3);
    chk("fill", 16'h0001, {15'h0, w >= 16'h0010});
    chk("concur on", 16'h0001, {15'h0, cco});
    for (n = 0; cs === 3'h1 && n < 100; n++) cyc(1);
    chk("delay", 16'h0001, {15'h0, n >= 20 && n <= 34});
    wait_step(3'h3); cyc(50);
    chk("never", 16'h0003, {13'h0, cs});
    chk("wdog", 16'h0001, {15'h0, wdo});
    chk("concur off", 16'h0000, {15'h0, cco});
    stp = 1; cyc(4); stp = 0;
    chk("stop", 16'h0000, {15'h0, act});
    $display("batch tests done");
    ccv = 16'h0002; ce = 3'h5; wdv = 16'h0064;
    wr(3'h0, {1'b0, 4'h4, 16'h0002}); wr(3'h1, {1'b1, 4'h1, 16'h0020});
    wr(3'h2, {1'b0, 4'h3, 16'h0000}); wr(3'h3, {1'b0, 4'h2, 16'h0003});
    wr(3'h4, {1'b0, 4'h5, 16'h0001}); wr(3'h5, {1'b0, 4'h1, 16'h00ff});
    wr(3'h6, {1'b0, 4'h6, 16'h0000}); wr(3'h7, {1'b0, 4'h6, 16'h0000});
    bsr = 1; cyc(3); bsr = 0; cyc(2); wait_step(3'h3); setw(16'h001c);
    chk("concur timed", 16'h0000, {15'h0, cco});
    p = 3'h3; j = 0; k = 0;
    for (n = 0; act === 1'b1 && n < 3000; n++)
    begin
      j += jo; k += (cs == 3'h1 && p != 3'h1); p = cs; cyc(1);
    end
    chk("rejog", 16'h0001, {15'h0, j != 0});
    chk("rejog done", 16'h0001, {15'h0, w >= 16'h0020});
    chk("skip", 16'h0001, {15'h0, w < 16'h00ff});
    chk("repeat", 16'h0001, k[15:0]);
    chk("end idle", 16'h0000, {15'h0, act});
    chk("wdog quiet", 16'h0000, {15'h0, wdo});
    mode = bssq_pkg::MODE_AUTO; cyc(4);
    chk("auto", 16'h0001, {15'h0, act});
    mode = bssq_pkg::MODE_OFF; cyc(3);
    chk("off", 16'h0000, {15'h0, act});
    $display("repeat tests done");
    give_verdict;
  end
  initial
  begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule

// File: hw/bssq_pkg.sv
// Shared constants, step encodings and state type of the batch sequencer
package bssq_pkg;

  // ------------------------------------------------------------------
  // Step table entry layout
  // ------------------------------------------------------------------
  localparam int VAL_W     = 16;            // Value field width
  localparam int KIND_W    = 4;             // Step kind width
  localparam int VAL_LSB   = 0;             // Value field position
  localparam int KIND_LSB  = 16;            // Kind field position
  localparam int BATCH_BIT = 20;            // Batch flag position
  localparam int ENTRY_W   = 21;            // Whole entry width

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS    = 5;             // System clock period, ns
  localparam int TICK_MS   = 100;           // Timing tick, ms
  localparam int TICK_CYC  = TICK_MS * 1000000 / CLK_NS; // Cycles/tick

  // ------------------------------------------------------------------
  // Step kinds
  // ------------------------------------------------------------------
  localparam logic [KIND_W-1:0] K_OFF       = 4'h0; // Skipped
  localparam logic [KIND_W-1:0] K_WEIGHT    = 4'h1; // Fill to target
  localparam logic [KIND_W-1:0] K_DELAY     = 4'h2; // Timed hold
  localparam logic [KIND_W-1:0] K_STANDSTILL = 4'h3; // Standstill wait
  localparam logic [KIND_W-1:0] K_COUNTER   = 4'h4; // Repeat count
  localparam logic [KIND_W-1:0] K_REJOG     = 4'h5; // Automatic re-jog
  localparam logic [KIND_W-1:0] K_ALWAYS    = 4'h6; // Always satisfied
  localparam logic [KIND_W-1:0] K_NEVER     = 4'h7; // Never satisfied

  // ------------------------------------------------------------------
  // Batching modes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF    = 2'h0; // Batching disabled
  localparam logic [1:0] MODE_AUTO   = 2'h1; // Restart continuously
  localparam logic [1:0] MODE_MANUAL = 2'h2; // Start on request

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000; // Timers and counts
  localparam logic [VAL_W-1:0] ONE_V   = 16'h0001; // Unit step

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,                       // No batch running
    ST_FETCH = 2'b01,                       // Step entry being read
    ST_RUN   = 2'b10,                       // Step being evaluated
    ST_JOG   = 2'b11                        // Re-jog pulse running
  } bssq_state_t;

endpackage

// File: hw/bssq_step_mem.sv
// Step table memory with one write port and a registered read port
`timescale 1ns/1ps
module bssq_step_mem #(
  parameter int ADDR_W = 3,                 // Address width
  parameter int DATA_W = 21                 // Entry width
) (
  input  wire logic              clk,       // System clock
  input  wire logic              we,        // Write strobe
  input  wire logic [ADDR_W-1:0] waddr,     // Write address
  input  wire logic [DATA_W-1:0] wdata,     // Write data
  input  wire logic [ADDR_W-1:0] raddr,     // Read address
  output logic      [DATA_W-1:0] rdata_reg  // Read data, one cycle late
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] mem [2**ADDR_W];       // Step entries

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk)
  begin
    rdata_reg <= mem[raddr];
  end

endmodule

// File: hw/bssq_top.sv
// Batch setpoint sequencer: step engine and continuous monitors
`timescale 1ns/1ps
module bssq_top #(
  parameter int STEPS_W     = 3,                 // Step address width
  parameter int TICK_CYCLES = bssq_pkg::TICK_CYC // Cycles per tick
) (
  input  wire logic               clk,            // System clock
  input  wire logic               rstn,           // Sync reset, low
  input  wire logic               cfg_we,         // Step table write
  input  wire logic [STEPS_W-1:0] cfg_addr,       // Step table address
  input  wire logic [20:0]        cfg_wdata,      // Step table entry
  input  wire logic [1:0]         batching_mode,  // Off/auto/manual
  input  wire logic               batch_start_request, // Start pin
  input  wire logic               batch_stop,     // Abort batch
  input  wire logic               standstill,     // Scale settled
  input  wire logic               gross_zero,     // Gross at zero
  input  wire logic               in_range,       // Within capacity
  input  wire logic [15:0]        weight,         // Scale weight
  input  wire logic [STEPS_W-1:0] wd_start_step,  // Watchdog start
  input  wire logic [STEPS_W-1:0] wd_end_step,    // Watchdog end
  input  wire logic [15:0]        wd_value,       // Watchdog tenths
  input  wire logic [STEPS_W-1:0] cc_start_step,  // Concur start
  input  wire logic [STEPS_W-1:0] cc_end_step,    // Concur end
  input  wire logic [15:0]        cc_value,       // Concur tenths
  input  wire logic [16:0]        tod_now,        // Clock, seconds
  input  wire logic [16:0]        tod_set,        // Setpoint time
  input  wire logic               delta_arm,      // Capture reference
  input  wire logic [15:0]        delta_value,    // Change threshold
  input  wire logic [15:0]        chk_over,       // Over limit
  input  wire logic [15:0]        chk_under,      // Under limit
  output logic      [STEPS_W-1:0] current_step,   // Active step
  output logic                    batch_active_monitor, // Batch runs
  output logic                    feed_out,       // Weight step output
  output logic                    jog_out,        // Re-jog indicator
  output logic                    zero_centre_monitor, // At zero
  output logic                    motion_monitor, // In motion
  output logic                    range_monitor,  // In range
  output logic                    watchdog_out,   // Watchdog expired
  output logic                    concur_out,     // Concurrent output
  output logic                    clock_match_setpoint, // Time hit
  output logic                    delta_met,      // Change reached
  output logic                    chk_over_out,   // Overweight
  output logic                    chk_under_out,  // Underweight
  output logic                    chk_accept_out  // Accepted
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES + 1);    // Divider width
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [STEPS_W-1:0] LAST = '1;       // Final step

  bssq_pkg::bssq_state_t state_reg;              // Sequencer state
  logic [STEPS_W-1:0] step_reg;                   // Current step
  logic               entry_reg;                  // First RUN cycle
  logic [TW-1:0]      div_reg;                    // Tick divider
  logic               tick_reg;                   // Tenth-second pulse
  logic [15:0]        tmr_reg;                    // Delay/jog timer
  logic [15:0]        cnt_left_reg;               // Batches remaining
  logic               cnt_loaded_reg;             // Count captured
  logic [15:0]        prev_tgt_reg;               // Last weight target
  logic [2:0]         start_sync_reg;             // Start pin sync
  logic [20:0]        entry_data;                 // Step entry read
  logic [3:0]         kind;                       // Current step kind
  logic [15:0]        val;                        // Current step value
  logic               advance;                    // Step satisfied
  logic               jog_begin;                  // Start re-jog pulse
  logic               restart;                    // Run again
  logic               abort;                      // Drop to idle
  logic               start_pulse;                // Start request edge
  logic               step_entry;                 // Step just entered
  logic               wd_run_reg;                 // Watchdog timing
  logic [15:0]        wd_cnt_reg;                 // Watchdog ticks
  logic [15:0]        cc_tmr_reg;                 // Concur ticks left
  logic               tod_prev_reg;               // Previous match
  logic [15:0]        delta_ref_reg;              // Change reference

  // Weight meets or passes a target
  function automatic logic reached(input logic [15:0] w,
                                   input logic [15:0] t);
    reached = (w >= t);
  endfunction

  // ------------------------------------------------------------------
  // Step table
  // ------------------------------------------------------------------
  bssq_step_mem #(
    .ADDR_W (STEPS_W),
    .DATA_W (bssq_pkg::ENTRY_W)
  ) u_mem (
    .clk       (clk),
    .we        (cfg_we),
    .waddr     (cfg_addr),
    .wdata     (cfg_wdata),
    .raddr     (step_reg),
    .rdata_reg (entry_data)
  );

  assign kind = entry_data[bssq_pkg::KIND_LSB +: bssq_pkg::KIND_W];
  assign val  = entry_data[bssq_pkg::VAL_LSB +: bssq_pkg::VAL_W];

  // ------------------------------------------------------------------
  // Tick and start request
  // ------------------------------------------------------------------
  // Tenth-second tick divider
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (div_reg == TICK_LAST);
      div_reg  <= (div_reg == TICK_LAST) ? '0 : div_reg + 1'b1;
    end
  end

  // Start pin synchroniser with edge stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      start_sync_reg <= 3'h0;
    end
    else
    begin
      start_sync_reg <= {start_sync_reg[1:0], batch_start_request};
    end
  end

  assign start_pulse = start_sync_reg[1] & ~start_sync_reg[2];
  assign abort = batch_stop || (batching_mode == bssq_pkg::MODE_OFF);
  assign step_entry = (state_reg == bssq_pkg::ST_RUN) && entry_reg;

  // ------------------------------------------------------------------
  // Step evaluation
  // ------------------------------------------------------------------
  // Decide whether the current step is satisfied
  always_comb
  begin
    advance   = 1'b0;
    jog_begin = 1'b0;
    if (state_reg == bssq_pkg::ST_RUN && !entry_reg)
    begin
      case (kind)
        bssq_pkg::K_WEIGHT:
          advance = !entry_data[bssq_pkg::BATCH_BIT] || reached(weight, val);
        bssq_pkg::K_DELAY:
          advance = (tmr_reg == bssq_pkg::VAL_RST);
        bssq_pkg::K_STANDSTILL:
          advance = standstill;
        bssq_pkg::K_REJOG:
        begin
          if (standstill)
          begin
            advance   = reached(weight, prev_tgt_reg);
            jog_begin = !reached(weight, prev_tgt_reg);
          end
        end
        bssq_pkg::K_NEVER:
          advance = 1'b0;
        default:
          advance = 1'b1;
      endcase
    end
  end

  // Repeat or auto mode starts the sequence again
  assign restart = (cnt_loaded_reg && cnt_left_reg > bssq_pkg::ONE_V) ||
                   (batching_mode == bssq_pkg::MODE_AUTO);

  // ------------------------------------------------------------------
  // Sequencer state machine
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg <= bssq_pkg::ST_IDLE;
      step_reg  <= '0;
      entry_reg <= 1'b0;
    end
    else if (abort)
    begin
      state_reg <= bssq_pkg::ST_IDLE;
      entry_reg <= 1'b0;
    end
    else
    begin
      entry_reg <= (state_reg == bssq_pkg::ST_FETCH);
      case (state_reg)
        bssq_pkg::ST_IDLE:
        begin
          // Auto runs at once, manual waits for a request
          if (batching_mode == bssq_pkg::MODE_AUTO || start_pulse)
          begin
            step_reg  <= '0;
            state_reg <= bssq_pkg::ST_FETCH;
          end
        end
        bssq_pkg::ST_FETCH:
          state_reg <= bssq_pkg::ST_RUN;
        bssq_pkg::ST_RUN:
        begin
          if (jog_begin)
            state_reg <= bssq_pkg::ST_JOG;
          else if (advance && step_reg == LAST)
          begin
            step_reg  <= '0;
            state_reg <= restart ? bssq_pkg::ST_FETCH
                                 : bssq_pkg::ST_IDLE;
          end
          else if (advance)
          begin
            step_reg  <= step_reg + 1'b1;
            state_reg <= bssq_pkg::ST_FETCH;
          end
        end
        bssq_pkg::ST_JOG:
        begin
          // Back to re-check after the pulse
          if (tmr_reg == bssq_pkg::VAL_RST)
            state_reg <= bssq_pkg::ST_RUN;
        end
        default:
          state_reg <= bssq_pkg::ST_IDLE;
      endcase
    end
  end

  // Delay and re-jog timer in ticks
  always_ff @(posedge clk)
  begin
    if (!rstn)
      tmr_reg <= bssq_pkg::VAL_RST;
    else if (step_entry || jog_begin)
      tmr_reg <= val;
    else if (tick_reg && tmr_reg != bssq_pkg::VAL_RST)
      tmr_reg <= tmr_reg - bssq_pkg::ONE_V;
  end

  // Batch repeat count
  always_ff @(posedge clk)
  begin
    if (!rstn || abort)
    begin
      cnt_left_reg   <= bssq_pkg::VAL_RST;
      cnt_loaded_reg <= 1'b0;
    end
    else if (advance && kind == bssq_pkg::K_COUNTER && !cnt_loaded_reg)
    begin
      cnt_left_reg   <= val;
      cnt_loaded_reg <= 1'b1;
    end
    else if (advance && step_reg == LAST)
    begin
      if (cnt_left_reg > bssq_pkg::ONE_V)
        cnt_left_reg <= cnt_left_reg - bssq_pkg::ONE_V;
      else
        cnt_loaded_reg <= 1'b0;
    end
  end

  // Target of the latest batch weight step
  always_ff @(posedge clk)
  begin
    if (!rstn)
      prev_tgt_reg <= bssq_pkg::VAL_RST;
    else if (step_entry && kind == bssq_pkg::K_WEIGHT &&
             entry_data[bssq_pkg::BATCH_BIT])
      prev_tgt_reg <= val;
  end

  // ------------------------------------------------------------------
  // Watchdog and concurrent output
  // ------------------------------------------------------------------
  // Watchdog between start and end steps
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wd_run_reg   <= 1'b0;
      wd_cnt_reg   <= bssq_pkg::VAL_RST;
      watchdog_out <= 1'b0;
    end
    else if (step_entry && step_reg == wd_start_step)
    begin
      wd_run_reg   <= 1'b1;
      wd_cnt_reg   <= bssq_pkg::VAL_RST;
      // Expiry in the same cycle wins over the clear
      watchdog_out <= wd_run_reg && (wd_cnt_reg >= wd_value);
    end
    else if ((step_entry && step_reg == wd_end_step) || abort)
      wd_run_reg <= 1'b0;
    else if (wd_run_reg && wd_cnt_reg >= wd_value)
    begin
      watchdog_out <= 1'b1;
      wd_run_reg   <= 1'b0;
    end
    else if (wd_run_reg && tick_reg)
      wd_cnt_reg <= wd_cnt_reg + bssq_pkg::ONE_V;
  end

  // Concurrent output, step-bounded or timed
  always_ff @(posedge clk)
  begin
    if (!rstn || abort)
    begin
      concur_out <= 1'b0;
      cc_tmr_reg <= bssq_pkg::VAL_RST;
    end
    else if (step_entry && step_reg == cc_start_step)
    begin
      concur_out <= 1'b1;
      cc_tmr_reg <= cc_value;
    end
    else if (cc_value == bssq_pkg::VAL_RST)
    begin
      if (step_entry && step_reg == cc_end_step)
        concur_out <= 1'b0;
    end
    else if (concur_out && tick_reg)
    begin
      cc_tmr_reg <= cc_tmr_reg - bssq_pkg::ONE_V;
      if (cc_tmr_reg <= bssq_pkg::ONE_V)
        concur_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Continuous monitors and step outputs
  // ------------------------------------------------------------------
  // Scale condition, batch activity and current step monitors
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      zero_centre_monitor  <= 1'b0;
      motion_monitor       <= 1'b0;
      range_monitor        <= 1'b0;
      batch_active_monitor <= 1'b0;
      current_step         <= '0;
    end
    else
    begin
      zero_centre_monitor  <= gross_zero;
      motion_monitor       <= !standstill;
      range_monitor        <= in_range;
      batch_active_monitor <= (state_reg != bssq_pkg::ST_IDLE);
      current_step         <= step_reg;
    end
  end

  // Fill and re-jog outputs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      feed_out <= 1'b0;
      jog_out  <= 1'b0;
    end
    else
    begin
      feed_out <= (state_reg == bssq_pkg::ST_JOG) ||
                  (state_reg == bssq_pkg::ST_RUN && !entry_reg &&
                   kind == bssq_pkg::K_WEIGHT &&
                   entry_data[bssq_pkg::BATCH_BIT] && !reached(weight, val));
      jog_out  <= (state_reg == bssq_pkg::ST_JOG);
    end
  end

  // Time match, weight change and checkweigher
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tod_prev_reg         <= 1'b0;
      clock_match_setpoint <= 1'b0;
      delta_ref_reg        <= bssq_pkg::VAL_RST;
      delta_met            <= 1'b0;
      chk_over_out         <= 1'b0;
      chk_under_out        <= 1'b0;
      chk_accept_out       <= 1'b0;
    end
    else
    begin
      tod_prev_reg         <= (tod_now == tod_set);
      clock_match_setpoint <= (tod_now == tod_set) && !tod_prev_reg;
      if (delta_arm)
        delta_ref_reg <= weight;
      delta_met <= !delta_arm &&
        (reached(weight, delta_ref_reg) ?
         (weight - delta_ref_reg) >= delta_value :
         (delta_ref_reg - weight) >= delta_value);
      chk_over_out   <= weight > chk_over;
      chk_under_out  <= weight < chk_under;
      chk_accept_out <= !(weight > chk_over) && !(weight < chk_under);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_jog_need;
    state_reg == bssq_pkg::ST_RUN && !entry_reg && !abort &&
    kind == bssq_pkg::K_REJOG && standstill &&
    !reached(weight, prev_tgt_reg);
  endsequence

  sequence s_jog_pulse;
    state_reg == bssq_pkg::ST_JOG ##1 jog_out && feed_out;
  endsequence

  rejog_pulse_a: assert property (s_jog_need |=> s_jog_pulse)
    else $error("re-jog did not pulse the fill output");
  ss_wait_a: assert property (state_reg == bssq_pkg::ST_RUN &&
      !entry_reg && !abort && kind == bssq_pkg::K_STANDSTILL &&
      !standstill |=> state_reg == bssq_pkg::ST_RUN && $stable(step_reg))
    else $error("standstill wait advanced while moving");
  never_step_a: assert property (state_reg == bssq_pkg::ST_RUN &&
      !entry_reg && !abort && kind == bssq_pkg::K_NEVER
      |=> $stable(step_reg) && state_reg == bssq_pkg::ST_RUN)
    else $error("never step was passed");
  delay_hold_a: assert property (state_reg == bssq_pkg::ST_RUN &&
      !entry_reg && kind == bssq_pkg::K_DELAY && tmr_reg != bssq_pkg::VAL_RST
      |=> $stable(step_reg))
    else $error("delay step ended early");
  tick_pulse_a: assert property (tick_reg |=> !tick_reg [*2])
    else $error("tick lasted more than one cycle");
  motion_mon_a: assert property (##1 motion_monitor ==
      !$past(standstill))
    else $error("motion output disagrees with standstill");
  zero_mon_a: assert property (gross_zero && in_range |=>
      zero_centre_monitor && range_monitor)
    else $error("zero or range output missing");
  batch_act_a: assert property (state_reg == bssq_pkg::ST_FETCH
      |=> batch_active_monitor)
    else $error("batch active output low during a batch");
  chk_excl_a: assert property (weight > chk_over |=>
      chk_over_out && !chk_accept_out)
    else $error("checkweigher accepted overweight");
  manual_idle_a: assert property (state_reg == bssq_pkg::ST_IDLE &&
      batching_mode == bssq_pkg::MODE_MANUAL && !start_pulse
      |=> state_reg == bssq_pkg::ST_IDLE)
    else $error("manual batch began without a request");

endmodule
